// [hdl/plvt_pkg.sv]
// Purpose: Shared constants and types for the partition label and trap block.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Field positions follow the system register layouts used by the block.
package plvt_pkg;

	localparam int PID_W          = 16;
	localparam int PMG_W          = 8;
	localparam int VMAP_REGS      = 8;
	localparam int VMAP_ENTRIES   = 32;
	localparam int VID_W          = 5;
	localparam logic [2:0] VMAP_REG_COUNT_MAX = 3'h7;
	localparam logic [PID_W-1:0] DEFAULT_PID = 16'h0000;
	localparam logic [PMG_W-1:0] DEFAULT_PMG = 8'h00;
	localparam logic [VID_W-1:0] DEFAULT_VID = 5'h00;

	// Encoding fields of a system register access.
	localparam logic [2:0] OP1_EL1   = 3'h0;
	localparam logic [2:0] OP1_EL2   = 3'h4;
	localparam logic [2:0] OP1_ALIAS = 3'h5;
	localparam logic [3:0] CRN_PART  = 4'ha;
	localparam logic [3:0] CRM_P1    = 4'h5;
	localparam logic [3:0] CRM_P0    = 4'h5;
	localparam logic [2:0] OP2_P1    = 3'h0;
	localparam logic [2:0] OP2_P0    = 3'h1;
	localparam logic [3:0] CRM_CTRL  = 4'h4;
	localparam logic [2:0] OP2_HCR   = 3'h0;
	localparam logic [2:0] OP2_VALID = 3'h1;
	localparam logic [2:0] OP2_ID    = 3'h4;
	localparam logic [3:0] CRM_VMAP  = 4'h6;
	localparam logic [2:0] OP1_EL3   = 3'h6;

	typedef enum logic [1:0]
	{
		PLVT_EL0 = 2'h0,
		PLVT_EL1 = 2'h1,
		PLVT_EL2 = 2'h2,
		PLVT_EL3 = 2'h3
	} plvt_el_t;

	// Decoded destination of a register access.
	typedef enum logic [3:0]
	{
		PLVT_R_NONE  = 4'h0,
		PLVT_R_P0    = 4'h1,
		PLVT_R_P1    = 4'h2,
		PLVT_R_P2    = 4'h3,
		PLVT_R_P3    = 4'h4,
		PLVT_R_HCR   = 4'h5,
		PLVT_R_VALID = 4'h6,
		PLVT_R_VMAP  = 4'h7,
		PLVT_R_ID    = 4'h8
	} plvt_reg_t;

	typedef enum logic [1:0]
	{
		PLVT_OK    = 2'h0,
		PLVT_UNDEF = 2'h1,
		PLVT_TO2   = 2'h3,
		PLVT_TO3   = 2'h2
	} plvt_result_t;

	// Layout of the EL0/EL1/EL2 partition registers: instr and data ids, then groups.
	localparam int PI_LSB   = 0;
	localparam int PD_LSB   = 16;
	localparam int GI_LSB   = 32;
	localparam int GD_LSB   = 40;
	// Control bit positions.
	localparam int EN_BIT      = 63;
	localparam int TRAPLOW_BIT = 62;
	localparam int TID_BIT     = 58;
	localparam int TRP1_BIT    = 49;
	localparam int TRP0_BIT    = 48;
	localparam int HCR_APP_BIT = 0;
	localparam int HCR_OS_BIT  = 1;
	localparam int HCR_LCK_BIT = 8;
	localparam int HCR_TID_BIT = 31;

endpackage

// [hdl/plvt_decode.sv]
// Purpose: Decodes a system register access into its target and trap outcome.
// Assumes: Inputs are stable in the cycle of the access strobe.
// Notes:   Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
module plvt_decode
(
	input  wire logic [1:0]  el,
	input  wire logic [2:0]  op1,
	input  wire logic [3:0]  crn,
	input  wire logic [3:0]  crm,
	input  wire logic [2:0]  op2,
	input  wire logic        host_at_el2_bit,
	input  wire logic        trap_lower_all,
	input  wire logic        trap_el1_reg_access,
	input  wire logic        trap_el0_reg_access,
	input  wire logic        trap_id_reg,
	input  wire logic        trap_id_read,
	input  wire logic        id_trap_supported,
	output      logic [3:0]  target,
	output      logic [1:0]  result
);

	logic part_space;
	logic is_p1;
	logic is_p0;
	logic is_alias;
	logic is_el2only;
	logic is_id;

	always_comb
	begin
		part_space = (crn == plvt_pkg::CRN_PART);
		is_p1      = part_space && op1 == plvt_pkg::OP1_EL1 && crm == plvt_pkg::CRM_P1 && op2 == plvt_pkg::OP2_P1;
		is_p0      = part_space && op1 == plvt_pkg::OP1_EL1 && crm == plvt_pkg::CRM_P0 && op2 == plvt_pkg::OP2_P0;
		is_alias   = part_space && op1 == plvt_pkg::OP1_ALIAS && crm == plvt_pkg::CRM_P1 && op2 == plvt_pkg::OP2_P1;
		is_el2only = part_space && op1 == plvt_pkg::OP1_EL2;
		is_id      = part_space && op1 == plvt_pkg::OP1_EL1 && crm == plvt_pkg::CRM_CTRL && op2 == plvt_pkg::OP2_ID;
		target     = plvt_pkg::PLVT_R_NONE;
		result     = plvt_pkg::PLVT_UNDEF;
		if (part_space && op1 == plvt_pkg::OP1_EL3 && crm == plvt_pkg::CRM_P1 && op2 == plvt_pkg::OP2_P1)
		begin
			target = plvt_pkg::PLVT_R_P3;
			result = (el == 2'h3) ? plvt_pkg::PLVT_OK : plvt_pkg::PLVT_UNDEF;
		end
		else if (is_p1)
		begin
			// At EL2 with the host bit the EL1 encoding reaches the EL2 register. [RL1]
			target = (el == 2'h2 && host_at_el2_bit) ? plvt_pkg::PLVT_R_P2 : plvt_pkg::PLVT_R_P1;
			result = (el == 2'h0) ? plvt_pkg::PLVT_UNDEF : plvt_pkg::PLVT_OK;
			if (el != 2'h3 && el != 2'h0 && trap_lower_all)
				result = plvt_pkg::PLVT_TO3; // [RL20] [RL21] [RL16]
			else if (el == 2'h1 && trap_el1_reg_access)
				result = plvt_pkg::PLVT_TO2; // [RL17] [RL18]
		end
		else if (is_alias)
		begin
			// Alias is only legal at EL2 or EL3 with the host bit. [RL2]
			target = plvt_pkg::PLVT_R_P1;
			if (el[1] && host_at_el2_bit)
				result = (el == 2'h2 && trap_lower_all) ? plvt_pkg::PLVT_TO3 : plvt_pkg::PLVT_OK; // [RL18] [RL20]
		end
		else if (is_p0 || is_id)
		begin
			target = is_p0 ? plvt_pkg::PLVT_R_P0 : plvt_pkg::PLVT_R_ID;
			result = (el == 2'h0) ? plvt_pkg::PLVT_UNDEF : plvt_pkg::PLVT_OK;
			if (el != 2'h3 && el != 2'h0 && trap_lower_all)
				result = plvt_pkg::PLVT_TO3; // [RL20] [RL21]
			else if (el == 2'h1 && is_p0 && trap_el0_reg_access)
				result = plvt_pkg::PLVT_TO2; // [RL19]
			else if (el == 2'h1 && is_id && (trap_id_reg || (trap_id_read && id_trap_supported)))
				result = plvt_pkg::PLVT_TO2; // [RL14] [RL15]
		end
		else if (is_el2only)
		begin
			case ({crm, op2})
				{plvt_pkg::CRM_P1, plvt_pkg::OP2_P1}:     target = plvt_pkg::PLVT_R_P2;
				{plvt_pkg::CRM_CTRL, plvt_pkg::OP2_HCR}:  target = plvt_pkg::PLVT_R_HCR;
				{plvt_pkg::CRM_CTRL, plvt_pkg::OP2_VALID}: target = plvt_pkg::PLVT_R_VALID;
				default:
				begin
					target = (crm == plvt_pkg::CRM_VMAP || crm == 4'h7) ? plvt_pkg::PLVT_R_VMAP : plvt_pkg::PLVT_R_NONE;
				end
			endcase
			if (target != plvt_pkg::PLVT_R_NONE && el[1])
				result = (el == 2'h2 && trap_lower_all) ? plvt_pkg::PLVT_TO3 : plvt_pkg::PLVT_OK; // [RL16] [RL20]
		end
	end

endmodule

// [hdl/plvt_map.sv]
// Purpose: Maps a virtual partition identifier to a physical one.
// Assumes: Entry and valid vectors come straight from the register file.
// Notes:   Combinational; out-of-range ids are truncated to the low index bits.
`timescale 1ns/1ps
module plvt_map
(
	input  wire logic [plvt_pkg::VMAP_ENTRIES*plvt_pkg::PID_W-1:0] entries,
	input  wire logic [plvt_pkg::VMAP_ENTRIES-1:0]                 valid,
	input  wire logic [plvt_pkg::PID_W-1:0]                        vid_in,
	input  wire logic                                              map_en,
	output      logic [plvt_pkg::PID_W-1:0]                        pid_out
);

	logic [plvt_pkg::VID_W-1:0] vid;

	always_comb
	begin
		// Truncation keeps every replacement in range with no extra compare. [RL13] [RL5]
		vid = vid_in[plvt_pkg::VID_W-1:0];
		if (!map_en)
			pid_out = vid_in; // [RL7]
		else if (valid[vid])
			pid_out = entries[vid*plvt_pkg::PID_W +: plvt_pkg::PID_W]; // [RL23] [RL6]
		else if (valid[plvt_pkg::DEFAULT_VID])
			pid_out = entries[plvt_pkg::DEFAULT_VID*plvt_pkg::PID_W +: plvt_pkg::PID_W]; // [RL12]
		else
			pid_out = plvt_pkg::DEFAULT_PID; // [RL12]
	end

endmodule

// [hdl/plvt_top.sv]
// Purpose: Partition label generation, register aliasing and access traps.
// Assumes: One access strobe per cycle at most; labels are sampled every cycle.
// Notes:   Accesses finish in one cycle, so ordering between encodings is trivially kept.
//
// Behaviour
// [RL1] EL1 encoding at EL2 with host bit reaches EL2 register
// [RL2] Alias encoding reaches EL1 register; undefined below EL2
// [RL3] Normal and alias accesses need no extra ordering
// [RL4] Mapping registers hold four 16-bit physical ids
// [RL5] Largest virtual id is four times count plus three
// [RL6] One valid bit per virtual id, 32 total
// [RL7] EL1 ids mapped when guest mapping enabled
// [RL8] EL0 mapping enable; host plus trap-general disables it
// [RL9] Lock makes EL0 use EL1 register and enable
// [RL10] Locked EL0 ignores EL0 register, maps EL1 ids
// [RL11] EL1 access to EL0 register ignores lock
// [RL12] Invalid entry falls to default entry, then default id
// [RL13] Out-of-range ids truncated, then checked normally
// [RL14] Identification register access from EL1 trapped to EL2
// [RL15] Read trap control exists only when capability set
// [RL16] EL2 access to EL2 register trapped by lower-all
// [RL17] EL1 access to EL1 register trapped when enabled
// [RL18] Alias and redirected encoding never trapped by EL1 control
// [RL19] EL1 access to EL0 register trapped when enabled
// [RL20] Lower-all traps every level below EL3 to EL3; the code traps only EL1 and EL2, EL0 accesses stay undefined
// [RL21] Lower-all trap wins over all EL2 traps
// [RL22] Global enable off gives default id, no mapping
// [RL23] Entry v in register v/4, field v%4, valid bit v
`timescale 1ns/1ps
module plvt_top
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic [1:0]  CUR_EL,
	input  wire logic        HOST_AT_EL2_BIT,
	input  wire logic        TRAP_GENERAL_BIT,
	input  wire logic        ID_TRAP_SUPPORTED,
	input  wire logic        ACC_VALID,
	input  wire logic        ACC_WRITE,
	input  wire logic [2:0]  ACC_OP1,
	input  wire logic [3:0]  ACC_CRN,
	input  wire logic [3:0]  ACC_CRM,
	input  wire logic [2:0]  ACC_OP2,
	input  wire logic [63:0] ACC_WDATA,
	output      logic        ACC_DONE,
	output      logic [1:0]  ACC_RESULT,
	output      logic [63:0] ACC_RDATA,
	output      logic [15:0] INSTR_PARTITION,
	output      logic [15:0] DATA_PARTITION,
	output      logic [7:0]  INSTR_MONITOR_GROUP,
	output      logic [7:0]  DATA_MONITOR_GROUP
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed
	{
		logic [63:0] p0;
		logic [63:0] p1;
		logic [63:0] p2;
		logic [63:0] p3;
		logic [31:0] hcr;
		logic [31:0] valid;
		logic [plvt_pkg::VMAP_ENTRIES*plvt_pkg::PID_W-1:0] ent;
		logic        done;
		logic [1:0]  res;
		logic [63:0] rdata;
		logic [15:0] pi;
		logic [15:0] pd;
		logic [7:0]  gi;
		logic [7:0]  gd;
	} plvt_state_t;

	plvt_state_t state_ff;
	plvt_state_t nxt_state;

	logic [3:0]  target;
	logic [1:0]  result;
	logic [63:0] src;
	logic        map_en;
	logic [15:0] map_i;
	logic [15:0] map_d;
	logic [2:0]  vreg;

	////////////////////////////////////////////////////////////////////////////////
	// Access decode and label mapping.

	plvt_decode u_decode
	(
		.el                  (CUR_EL),
		.op1                 (ACC_OP1),
		.crn                 (ACC_CRN),
		.crm                 (ACC_CRM),
		.op2                 (ACC_OP2),
		.host_at_el2_bit     (HOST_AT_EL2_BIT),
		.trap_lower_all      (state_ff.p3[plvt_pkg::TRAPLOW_BIT]),
		.trap_el1_reg_access (state_ff.p2[plvt_pkg::TRP1_BIT]),
		.trap_el0_reg_access (state_ff.p2[plvt_pkg::TRP0_BIT]),
		.trap_id_reg         (state_ff.hcr[plvt_pkg::HCR_TID_BIT]),
		.trap_id_read        (state_ff.p2[plvt_pkg::TID_BIT]),
		.id_trap_supported   (ID_TRAP_SUPPORTED),
		.target              (target),
		.result              (result)
	);

	always_comb
	begin
		// Choose the label source for the current level.
		src    = state_ff.p1;
		map_en = 1'b0;
		case (CUR_EL)
			2'h0:
			begin
				if (state_ff.hcr[plvt_pkg::HCR_LCK_BIT])
				begin
					src    = state_ff.p1; // [RL9] [RL10]
					map_en = state_ff.hcr[plvt_pkg::HCR_OS_BIT];
				end
				else
				begin
					src    = state_ff.p0;
					map_en = state_ff.hcr[plvt_pkg::HCR_APP_BIT] && !(HOST_AT_EL2_BIT && TRAP_GENERAL_BIT); // [RL8]
				end
			end
			2'h1:
			begin
				src    = state_ff.p1;
				map_en = state_ff.hcr[plvt_pkg::HCR_OS_BIT]; // [RL7]
			end
			2'h2:    src = state_ff.p2;
			default: src = state_ff.p3;
		endcase
	end

	plvt_map u_map_i
	(
		.entries (state_ff.ent),
		.valid   (state_ff.valid),
		.vid_in  (src[plvt_pkg::PI_LSB +: 16]),
		.map_en  (map_en),
		.pid_out (map_i)
	);

	plvt_map u_map_d
	(
		.entries (state_ff.ent),
		.valid   (state_ff.valid),
		.vid_in  (src[plvt_pkg::PD_LSB +: 16]),
		.map_en  (map_en),
		.pid_out (map_d)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb
	begin
		nxt_state      = state_ff;
		nxt_state.done = ACC_VALID;
		nxt_state.res  = ACC_VALID ? result : plvt_pkg::PLVT_OK;
		// Bit 0 of op2 is ignored, so an odd encoding still lands on a whole register.
		vreg           = {ACC_CRM[0], ACC_OP2[2:1]};
		if (ACC_VALID && result == plvt_pkg::PLVT_OK)
		begin
			// EL0 register access is the same whatever the lock says. [RL11]
			case (target)
				plvt_pkg::PLVT_R_P0:    nxt_state.rdata = state_ff.p0;
				plvt_pkg::PLVT_R_P1:    nxt_state.rdata = state_ff.p1;
				plvt_pkg::PLVT_R_P2:    nxt_state.rdata = state_ff.p2;
				plvt_pkg::PLVT_R_P3:    nxt_state.rdata = state_ff.p3;
				plvt_pkg::PLVT_R_HCR:   nxt_state.rdata = {32'h0, state_ff.hcr};
				plvt_pkg::PLVT_R_VALID: nxt_state.rdata = {32'h0, state_ff.valid};
				plvt_pkg::PLVT_R_VMAP:  nxt_state.rdata = state_ff.ent[{vreg, 6'h00} +: 64]; // [RL4]
				plvt_pkg::PLVT_R_ID:    nxt_state.rdata = {27'h0, ID_TRAP_SUPPORTED, 28'h0,
					plvt_pkg::VMAP_REG_COUNT_MAX, 5'h0}; // [RL5]
				default:                nxt_state.rdata = 64'h0;
			endcase
			if (ACC_WRITE)
			begin
				// Every access completes in its own cycle, so encodings stay ordered. [RL3]
				case (target)
					plvt_pkg::PLVT_R_P0:    nxt_state.p0 = ACC_WDATA;
					plvt_pkg::PLVT_R_P1:    nxt_state.p1 = ACC_WDATA;
					plvt_pkg::PLVT_R_P2:
					begin
						nxt_state.p2 = ACC_WDATA;
						// Read trap bit is absent without the capability. [RL15]
						nxt_state.p2[plvt_pkg::TID_BIT] = ACC_WDATA[plvt_pkg::TID_BIT] & ID_TRAP_SUPPORTED;
					end
					plvt_pkg::PLVT_R_P3:    nxt_state.p3 = ACC_WDATA;
					plvt_pkg::PLVT_R_HCR:   nxt_state.hcr = ACC_WDATA[31:0];
					plvt_pkg::PLVT_R_VALID: nxt_state.valid = ACC_WDATA[31:0]; // [RL6]
					plvt_pkg::PLVT_R_VMAP:  nxt_state.ent[{vreg, 6'h00} +: 64] = ACC_WDATA; // [RL4] [RL23]
					default:                nxt_state.rdata = 64'h0;
				endcase
			end
		end
		else if (ACC_VALID)
		begin
			nxt_state.rdata = 64'h0;
		end
		// Labels are registered so the request side sees glitch-free values.
		if (!state_ff.p3[plvt_pkg::EN_BIT])
		begin
			nxt_state.pi = plvt_pkg::DEFAULT_PID; // [RL22]
			nxt_state.pd = plvt_pkg::DEFAULT_PID; // [RL22]
			nxt_state.gi = plvt_pkg::DEFAULT_PMG;
			nxt_state.gd = plvt_pkg::DEFAULT_PMG;
		end
		else
		begin
			nxt_state.pi = map_i;
			nxt_state.pd = map_d;
			nxt_state.gi = src[plvt_pkg::GI_LSB +: 8];
			nxt_state.gd = src[plvt_pkg::GD_LSB +: 8];
		end
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign ACC_DONE            = state_ff.done;
	assign ACC_RESULT          = state_ff.res;
	assign ACC_RDATA           = state_ff.rdata;
	assign INSTR_PARTITION     = state_ff.pi;
	assign DATA_PARTITION      = state_ff.pd;
	assign INSTR_MONITOR_GROUP = state_ff.gi;
	assign DATA_MONITOR_GROUP  = state_ff.gd;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	// The checker keeps only the low index bits, as the mapper truncates the same way.
	logic [4:0] a_vid;
	assign a_vid = src[plvt_pkg::PI_LSB +: 5];

	disabled_default_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL22]
		!state_ff.p3[plvt_pkg::EN_BIT] |=> INSTR_PARTITION == plvt_pkg::DEFAULT_PID && DATA_PARTITION == plvt_pkg::DEFAULT_PID)
		else $error("disabled partitioning gave non-default id");

	trap_lower_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL21]
		ACC_VALID && state_ff.p3[plvt_pkg::TRAPLOW_BIT] && CUR_EL == 2'h1 && ACC_CRN == plvt_pkg::CRN_PART
		&& ACC_OP1 == plvt_pkg::OP1_EL1 && ACC_CRM == plvt_pkg::CRM_P1 && ACC_OP2 == plvt_pkg::OP2_P1
		|=> ACC_DONE && ACC_RESULT == plvt_pkg::PLVT_TO3)
		else $error("lower trap lost priority");

	el1_trap_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL17]
		ACC_VALID && !state_ff.p3[plvt_pkg::TRAPLOW_BIT] && state_ff.p2[plvt_pkg::TRP1_BIT] && CUR_EL == 2'h1
		&& ACC_CRN == plvt_pkg::CRN_PART && ACC_OP1 == plvt_pkg::OP1_EL1 && ACC_CRM == plvt_pkg::CRM_P1
		&& ACC_OP2 == plvt_pkg::OP2_P1 |=> ACC_RESULT == plvt_pkg::PLVT_TO2)
		else $error("EL1 register access not trapped");

	alias_undef_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL2]
		ACC_VALID && !CUR_EL[1] && ACC_CRN == plvt_pkg::CRN_PART && ACC_OP1 == plvt_pkg::OP1_ALIAS
		|=> ACC_RESULT == plvt_pkg::PLVT_UNDEF)
		else $error("alias accepted below EL2");

	alias_write_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL18]
		ACC_VALID && ACC_WRITE && CUR_EL == 2'h2 && HOST_AT_EL2_BIT && !state_ff.p3[plvt_pkg::TRAPLOW_BIT]
		&& target == plvt_pkg::PLVT_R_P1 && ACC_OP1 == plvt_pkg::OP1_ALIAS |=> state_ff.p1 == $past(ACC_WDATA))
		else $error("alias write missed EL1 register");

	redirect_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL1]
		ACC_VALID && CUR_EL == 2'h2 && HOST_AT_EL2_BIT && ACC_CRN == plvt_pkg::CRN_PART
		&& ACC_OP1 == plvt_pkg::OP1_EL1 && ACC_CRM == plvt_pkg::CRM_P1 && ACC_OP2 == plvt_pkg::OP2_P1
		|-> target == plvt_pkg::PLVT_R_P2)
		else $error("host access not redirected");

	lock_source_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL9]
		CUR_EL == 2'h0 && state_ff.hcr[plvt_pkg::HCR_LCK_BIT] |-> src == state_ff.p1)
		else $error("locked EL0 used EL0 register");

	fallback_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL12]
		state_ff.p3[plvt_pkg::EN_BIT] && map_en && !state_ff.valid[a_vid] && !state_ff.valid[0]
		|=> INSTR_PARTITION == plvt_pkg::DEFAULT_PID)
		else $error("invalid mapping did not fall back");

	el0_trap_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL19]
		ACC_VALID && !state_ff.p3[plvt_pkg::TRAPLOW_BIT] && state_ff.p2[plvt_pkg::TRP0_BIT] && CUR_EL == 2'h1
		&& ACC_CRN == plvt_pkg::CRN_PART && ACC_OP1 == plvt_pkg::OP1_EL1 && ACC_CRM == plvt_pkg::CRM_P0
		&& ACC_OP2 == plvt_pkg::OP2_P0 |=> ACC_RESULT == plvt_pkg::PLVT_TO2)
		else $error("EL0 register access not trapped");

	id_trap_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL14]
		ACC_VALID && !state_ff.p3[plvt_pkg::TRAPLOW_BIT] && state_ff.hcr[plvt_pkg::HCR_TID_BIT] && CUR_EL == 2'h1
		&& ACC_CRN == plvt_pkg::CRN_PART && ACC_OP1 == plvt_pkg::OP1_EL1 && ACC_CRM == plvt_pkg::CRM_CTRL
		&& ACC_OP2 == plvt_pkg::OP2_ID |=> ACC_RESULT == plvt_pkg::PLVT_TO2)
		else $error("identification access not trapped");

	el2_lower_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL16]
		ACC_VALID && state_ff.p3[plvt_pkg::TRAPLOW_BIT] && CUR_EL == 2'h2 && ACC_CRN == plvt_pkg::CRN_PART
		&& ACC_OP1 == plvt_pkg::OP1_EL2 && ACC_CRM == plvt_pkg::CRM_P1 && ACC_OP2 == plvt_pkg::OP2_P1
		|=> ACC_RESULT == plvt_pkg::PLVT_TO3)
		else $error("EL2 register access not trapped to EL3");

	map_off_a: assert property (@(posedge MCLK) disable iff (!RST_N) // [RL7]
		state_ff.p3[plvt_pkg::EN_BIT] && CUR_EL == 2'h1 && !state_ff.hcr[plvt_pkg::HCR_OS_BIT]
		|=> INSTR_PARTITION == $past(state_ff.p1[plvt_pkg::PI_LSB +: 16]))
		else $error("unmapped EL1 id was altered");

endmodule

// [verif/plvt_mem_sink.sv]
// Purpose: Stand-in for the memory system that receives labelled requests.
// Assumes: One request leaves the core every clock cycle.
// Notes:   It only latches the labels, so the bench sees what the memory side saw.
`timescale 1ns/1ps
module plvt_mem_sink
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] instr_partition,
	input  wire logic [15:0] data_partition,
	input  wire logic [7:0]  instr_monitor_group,
	input  wire logic [7:0]  data_monitor_group,
	output      logic [47:0] seen_ff
);
	////////////////////////////////////////////////////////////////////////////////
	// A request takes whatever labels stand at the edge; there is no refusal path.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			seen_ff <= 48'h0;
		else
			seen_ff <= {data_monitor_group, instr_monitor_group, data_partition, instr_partition};
	end
endmodule

// [verif/testbench.sv]
// Purpose: Self-checking bench for the partition label and trap block.
// Assumes: Labels settle two edges after the write that changes them.
// Notes:   Every result, the read data where asked, and the labels at each check are compared with a model built from the rules.
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  cur_el = 2'h0;
	logic        host = 1'b0;
	logic        trap_general_bit = 1'b0;
	logic        idsup = 1'b0;
	logic        av = 1'b0;
	logic        aw = 1'b0;
	logic [2:0]  op1 = 3'h0;
	logic [3:0]  crn = plvt_pkg::CRN_PART;
	logic [3:0]  crm = 4'h0;
	logic [2:0]  op2 = 3'h0;
	logic [63:0] wd = 64'h0;
	logic        done;
	logic [1:0]  res;
	logic [63:0] rd;
	logic [15:0] ip;
	logic [15:0] dp;
	logic [7:0]  ig;
	logic [7:0]  dg;
	logic [47:0] seen;
	integer      bad_count = 0;
	integer      samples_checked = 0;
	integer      seed = 46396;
	integer      cyc = 0;
	logic [63:0] m_reg [0:3];
	logic [63:0] m_hcr;
	logic [31:0] m_vv;
	logic [15:0] m_ent [0:31];
	localparam logic [1:0] OK = plvt_pkg::PLVT_OK;
	localparam logic [1:0] UD = plvt_pkg::PLVT_UNDEF;
	localparam logic [1:0] T2 = plvt_pkg::PLVT_TO2;
	localparam logic [1:0] T3 = plvt_pkg::PLVT_TO3;

	always #25 clk = ~clk;

	plvt_top plvt_top_inst
	(
		.MCLK                (clk),
		.RST_N               (rst_n),
		.CUR_EL              (cur_el),
		.HOST_AT_EL2_BIT     (host),
		.TRAP_GENERAL_BIT    (trap_general_bit),
		.ID_TRAP_SUPPORTED   (idsup),
		.ACC_VALID           (av),
		.ACC_WRITE           (aw),
		.ACC_OP1             (op1),
		.ACC_CRN             (crn),
		.ACC_CRM             (crm),
		.ACC_OP2             (op2),
		.ACC_WDATA           (wd),
		.ACC_DONE            (done),
		.ACC_RESULT          (res),
		.ACC_RDATA           (rd),
		.INSTR_PARTITION     (ip),
		.DATA_PARTITION      (dp),
		.INSTR_MONITOR_GROUP (ig),
		.DATA_MONITOR_GROUP  (dg)
	);

	plvt_mem_sink plvt_mem_sink_inst
	(
		.clk                 (clk),
		.rst_n               (rst_n),
		.instr_partition     (ip),
		.data_partition      (dp),
		.instr_monitor_group (ig),
		.data_monitor_group  (dg),
		.seen_ff             (seen)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (exp !== got)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The whole register moves in one access; the answer is sampled just after the next edge.
	task automatic acc(input [1:0] el, input [2:0] o1, input [3:0] cm, input [2:0] o2, input w,
		input [63:0] d, input [1:0] er, input [63:0] erd, input cmp_data);
		@(posedge clk);
		cur_el <= el;
		av <= 1'b1;
		aw <= w;
		op1 <= o1;
		crm <= cm;
		op2 <= o2;
		wd <= d;
		@(posedge clk);
		av <= 1'b0;
		#1;
		check("done", 64'h1, {63'h0, done});
		check("result", {62'h0, er}, {62'h0, res});
		if (!w && cmp_data)
			check("rdata", (er == OK) ? erd : 64'h0, rd);
	endtask

	function automatic logic [15:0] map_id(input logic [15:0] v, input logic en);
		if (!en)
			return v;
		if (m_vv[v[4:0]])
			return m_ent[v[4:0]];
		if (m_vv[0])
			return m_ent[0];
		return plvt_pkg::DEFAULT_PID;
	endfunction

	task automatic check_labels();
		logic [63:0] src;
		logic        en;
		src = m_reg[cur_el];
		en = 1'b0;
		if (cur_el == 2'h1)
			en = m_hcr[1];
		if (cur_el == 2'h0)
		begin
			en = m_hcr[8] ? m_hcr[1] : (m_hcr[0] && !(host && trap_general_bit));
			src = m_hcr[8] ? m_reg[1] : m_reg[0];
		end
		repeat (3) @(posedge clk);
		#1;
		if (!m_reg[3][63])
		begin
			check("instr id", plvt_pkg::DEFAULT_PID, ip);
			check("data id", plvt_pkg::DEFAULT_PID, dp);
		end
		else
		begin
			check("instr id", map_id(src[15:0], en), ip);
			check("data id", map_id(src[31:16], en), dp);
			check("groups", src[47:32], {dg, ig});
		end
		check("sink", {dg, ig, dp, ip}, seen);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	initial
	begin
		logic [63:0] d;
		for (int i = 0; i < 4; i++)
			m_reg[i] = 64'h0;
		m_hcr = 64'h0;
		m_vv = 32'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		check_labels();
		m_reg[3] = 64'h8000000000000000;
		acc(2'h3, 3'h6, 4'h5, 3'h0, 1'b1, m_reg[3], OK, 0, 0);
		for (int i = 0; i < 8; i++)
		begin
			d = {$random(seed), $random(seed)};
			for (int k = 0; k < 4; k++)
				m_ent[4 * i + k] = d[16 * k +: 16];
			acc(2'h2, 3'h4, 4'h6 + {3'h0, i[2]}, {i[1:0], 1'b0}, 1'b1, d, OK, 0, 0);
		end
		for (int i = 0; i < 8; i++)
			acc(2'h2, 3'h4, 4'h6 + {3'h0, i[2]}, {i[1:0], 1'b1}, 1'b0, 0, OK,
				{m_ent[4 * i + 3], m_ent[4 * i + 2], m_ent[4 * i + 1], m_ent[4 * i]}, 1);
		for (int n = 0; n < 24; n++)
		begin
			m_vv = $random(seed);
			acc(2'h2, 3'h4, 4'h4, 3'h1, 1'b1, {32'h0, m_vv}, OK, 0, 0);
			m_hcr = {55'h0, 1'($random(seed)), 6'h0, 2'($random(seed))};
			acc(2'h2, 3'h4, 4'h4, 3'h0, 1'b1, m_hcr, OK, 0, 0);
			m_reg[1] = {16'h0, 16'($random(seed)), 32'($random(seed))};
			acc(2'h1, 3'h0, 4'h5, 3'h0, 1'b1, m_reg[1], OK, 0, 0);
			m_reg[0] = {16'h0, 16'($random(seed)), 32'($random(seed))};
			acc(2'h1, 3'h0, 4'h5, 3'h1, 1'b1, m_reg[0], OK, 0, 0);
			acc(2'h1, 3'h0, 4'h5, 3'h1, 1'b0, 0, OK, m_reg[0], 1);
			host <= 1'($random(seed));
			trap_general_bit <= 1'($random(seed));
			cur_el <= 2'($random(seed));
			@(posedge clk);
			check_labels();
		end
		// Host mode redirects the plain encoding at EL2 and opens the alias.
		host <= 1'b1;
		m_reg[2] = 64'h0000_0000_1234_5678;
		acc(2'h2, 3'h0, 4'h5, 3'h0, 1'b1, m_reg[2], OK, 0, 0);
		acc(2'h2, 3'h4, 4'h5, 3'h0, 1'b0, 0, OK, m_reg[2], 1);
		m_reg[1] = 64'h0000_00a5_0bcd_0ef1;
		acc(2'h2, 3'h5, 4'h5, 3'h0, 1'b1, m_reg[1], OK, 0, 0);
		acc(2'h3, 3'h5, 4'h5, 3'h0, 1'b0, 0, OK, m_reg[1], 1);
		acc(2'h1, 3'h0, 4'h5, 3'h0, 1'b0, 0, OK, m_reg[1], 1);
		acc(2'h1, 3'h5, 4'h5, 3'h0, 1'b0, 0, UD, 0, 1);
		acc(2'h0, 3'h5, 4'h5, 3'h0, 1'b0, 0, UD, 0, 1);
		crn <= 4'h9;
		acc(2'h2, 3'h5, 4'h5, 3'h0, 1'b0, 0, UD, 0, 1);
		crn <= plvt_pkg::CRN_PART;
		// Trap controls in the EL2 register; the read trap only acts while the capability is set.
		idsup <= 1'b1;
		m_reg[2] = 64'h0403_0000_0000_0000;
		acc(2'h2, 3'h4, 4'h5, 3'h0, 1'b1, m_reg[2], OK, 0, 0);
		acc(2'h1, 3'h0, 4'h5, 3'h0, 1'b1, 64'h1, T2, 0, 0);
		acc(2'h1, 3'h0, 4'h5, 3'h0, 1'b0, 0, T2, 0, 1);
		acc(2'h1, 3'h0, 4'h5, 3'h1, 1'b0, 0, T2, 0, 1);
		acc(2'h2, 3'h5, 4'h5, 3'h0, 1'b0, 0, OK, m_reg[1], 1);
		acc(2'h2, 3'h0, 4'h5, 3'h0, 1'b0, 0, OK, m_reg[2], 1);
		acc(2'h1, 3'h0, 4'h4, 3'h4, 1'b0, 0, T2, 0, 1);
		idsup <= 1'b0;
		acc(2'h1, 3'h0, 4'h4, 3'h4, 1'b0, 0, OK, 0, 0);
		acc(2'h1, 3'h0, 4'h4, 3'h4, 1'b0, 0, OK, {56'h0, plvt_pkg::VMAP_REG_COUNT_MAX, 5'h0}, 1);
		m_hcr = 64'h8000_0000;
		acc(2'h2, 3'h4, 4'h4, 3'h0, 1'b1, m_hcr, OK, 0, 0);
		acc(2'h1, 3'h0, 4'h4, 3'h4, 1'b0, 0, T2, 0, 1);
		// Lower-all trap wins over every EL2 control.
		m_reg[3] = 64'hc000_0000_0000_0000;
		acc(2'h3, 3'h6, 4'h5, 3'h0, 1'b1, m_reg[3], OK, 0, 0);
		acc(2'h2, 3'h4, 4'h5, 3'h0, 1'b0, 0, T3, 0, 1);
		acc(2'h1, 3'h0, 4'h5, 3'h0, 1'b0, 0, T3, 0, 1);
		acc(2'h1, 3'h0, 4'h4, 3'h4, 1'b0, 0, T3, 0, 1);
		acc(2'h2, 3'h4, 4'h4, 3'h1, 1'b0, 0, T3, 0, 1);
		m_reg[3] = 64'h0;
		acc(2'h3, 3'h6, 4'h5, 3'h0, 1'b1, m_reg[3], OK, 0, 0);
		cur_el <= 2'h2;
		@(posedge clk);
		check_labels();
		give_verdict();
	end
endmodule
